// *** core/rrs_exec.sv ***
// execution core for or, rotates, stack reload, returns, subtract with borrow
// assumes memory answers a read in the same cycle (comb mem_rdata)
module rrs_exec
    import rrs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    output logic [15:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    output logic [7:0] accumulator,
    output logic [7:0] index_reg,
    output logic [15:0] stack_pointer,
    output logic [15:0] program_counter,
    output logic [7:0] condition_flags,
    output logic instr_done,
    output logic illegal_op
);
    // ****************
    // state
    // ****************
    rrs_state_t st_q, st_d;
    rrs_kind_t kind_q, kind_d;
    logic [7:0] a_q, a_d, x_q, x_d, ccr_q, ccr_d, opc_q, opc_d;
    logic [15:0] sp_q, sp_d, pc_q, pc_d, ea_q, ea_d;
    logic [3:0] cyc_q, cyc_d;
    logic [2:0] pull_q, pull_d;
    logic [1:0] ofs_q, ofs_d;
    logic done_q, done_d, ill_q, ill_d;
    // ea_q holds the operand address; imm forms (opc_q[7:4] == a) read at pc_q instead

    // ****************
    // alu
    // ****************
    logic [7:0] opnd, res;
    logic cout;
    logic tgt_a, tgt_x, tgt_m;
    always_comb
    begin
        opnd = mem_rdata;
        tgt_a = (opc_q[7:4] == 4'h4);
        tgt_x = (opc_q[7:4] == 4'h5);
        tgt_m = !(tgt_a || tgt_x);
        if (tgt_a && kind_q != RRS_K_OR && kind_q != RRS_K_SBC)
            opnd = a_q;
        else if (tgt_x)
            opnd = x_q;
        res = BYTE_ZERO;
        cout = ccr_q[FLG_C];
        unique case (kind_q)
            RRS_K_OR:
                res = a_q | opnd;
            RRS_K_ROL:
            begin
                res = {opnd[MSB-1:0], ccr_q[FLG_C]}; // RULE2
                cout = opnd[MSB]; // RULE3
            end
            RRS_K_ROR:
            begin
                res = {ccr_q[FLG_C], opnd[MSB:1]}; // RULE4
                cout = opnd[0]; // RULE5
            end
            RRS_K_SBC:
            begin
                res = 8'(a_q - opnd - {7'h00, ccr_q[FLG_C]}); // RULE14
                cout = (!a_q[MSB] && opnd[MSB]) || (opnd[MSB] && res[MSB])
                    || (res[MSB] && !a_q[MSB]); // RULE15
            end
            default:
                res = BYTE_ZERO;
        endcase
    end

    // ****************
    // sequencer
    // ****************
    always_comb
    begin
        st_d = st_q;
        kind_d = kind_q;
        a_d = a_q;
        x_d = x_q;
        ccr_d = ccr_q; // RULE17
        opc_d = opc_q;
        sp_d = sp_q;
        pc_d = pc_q;
        ea_d = ea_q;
        cyc_d = cyc_q;
        pull_d = pull_q;
        ofs_d = ofs_q;
        done_d = 1'b0;
        ill_d = 1'b0;
        mem_addr = pc_q;
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        mem_wdata = res;
        unique case (st_q)
            RRS_FETCH:
            begin
                mem_rd = 1'b1;
                opc_d = mem_rdata;
                pc_d = pc_q + PC_STEP;
                cyc_d = CYC_ONE;
                ofs_d = 2'h0;
                ea_d = {8'h00, x_q};
                st_d = RRS_OPER;
                unique case (mem_rdata[3:0])
                    4'ha: kind_d = RRS_K_OR;
                    4'h9: kind_d = RRS_K_ROL;
                    4'h6: kind_d = RRS_K_ROR;
                    4'h2: kind_d = RRS_K_SBC;
                    default: kind_d = RRS_K_NONE;
                endcase
                // operand bytes following opcode per addressing mode
                unique case (mem_rdata[7:4])
                    4'ha, 4'hb, 4'h3, 4'h6, 4'he: ofs_d = 2'h1;
                    4'hc, 4'hd: ofs_d = 2'h2;
                    default: ofs_d = 2'h0;
                endcase
                if (mem_rdata == OP_STK_RELOAD || mem_rdata == OP_INT_RETURN
                    || mem_rdata == OP_SUB_RETURN)
                begin
                    kind_d = RRS_K_NONE;
                    ofs_d = 2'h0;
                    pull_d = (mem_rdata == OP_INT_RETURN) ? PULLS_RTI
                        : PULLS_RTS;
                    st_d = (mem_rdata == OP_STK_RELOAD) ? RRS_WAIT
                        : RRS_PULL;
                end
                else if (!(mem_rdata inside {OP_OR_IMM, OP_OR_DIR, OP_OR_EXT,
                    OP_OR_IX, OP_OR_IX1, OP_OR_IX2, OP_ROL_A, OP_ROL_X,
                    OP_ROL_DIR, OP_ROL_IX, OP_ROL_IX1, OP_ROR_A, OP_ROR_X,
                    OP_ROR_DIR, OP_ROR_IX, OP_ROR_IX1, OP_SBC_IMM, OP_SBC_DIR,
                    OP_SBC_EXT, OP_SBC_IX, OP_SBC_IX1, OP_SBC_IX2}))
                begin
                    // unknown codes retire as a no-op of cyc_target cycles (2 for high nibbles 0, 1, 2, 8, 9 and a, more for others)
                    kind_d = RRS_K_NONE;
                    ofs_d = 2'h0;
                    ill_d = 1'b1;
                    st_d = RRS_WAIT;
                end
            end
            RRS_OPER:
            begin
                cyc_d = cyc_q + CYC_ONE;
                if (ofs_q != 2'h0 && !(opc_q[7:4] == 4'ha))
                begin
                    // collect address bytes; indexed forms add x
                    mem_rd = 1'b1;
                    pc_d = pc_q + PC_STEP;
                    ofs_d = ofs_q - 2'h1;
                    if (opc_q[7:4] == 4'hb || opc_q[7:4] == 4'h3)
                        ea_d = {8'h00, mem_rdata};
                    else if (opc_q[7:4] == 4'hc || opc_q[7:4] == 4'hd)
                        ea_d = (ofs_q == 2'h2) ? {mem_rdata, 8'h00}
                            : ((opc_q[7:4] == 4'hd)
                            ? ea_q + {8'h00, mem_rdata} + {8'h00, x_q}
                            : {ea_q[15:8], mem_rdata});
                    else
                        ea_d = {8'h00, mem_rdata} + {8'h00, x_q};
                end
                else
                begin
                    mem_rd = tgt_m;
                    mem_addr = (opc_q[7:4] == 4'ha) ? pc_q : ea_q;
                    if (opc_q[7:4] == 4'ha)
                        pc_d = pc_q + PC_STEP;
                    mem_wr = tgt_m && (kind_q == RRS_K_ROL
                        || kind_q == RRS_K_ROR);
                    if (kind_q == RRS_K_OR || kind_q == RRS_K_SBC || tgt_a)
                        a_d = res; // RULE14
                    else if (tgt_x)
                        x_d = res;
                    ccr_d[FLG_Z] = (res == BYTE_ZERO); // RULE1 RULE6
                    ccr_d[FLG_N] = res[MSB]; // RULE1 RULE6
                    if (kind_q != RRS_K_OR)
                        ccr_d[FLG_C] = cout; // RULE3 RULE5 RULE15
                    st_d = RRS_WAIT;
                    // short forms retire here, a pad cycle would overrun
                    if (cyc_q + CYC_ONE >= cyc_target(opc_q))
                    begin
                        done_d = 1'b1; // RULE16
                        st_d = RRS_FETCH;
                    end
                end
            end
            RRS_PULL:
            begin
                cyc_d = cyc_q + CYC_ONE;
                if (pull_q != 3'h0)
                begin
                    sp_d = sp_q + STACK_STEP; // RULE9 RULE12
                    mem_addr = sp_d;
                    mem_rd = 1'b1;
                    pull_d = pull_q - 3'h1;
                    unique case (pull_q)
                        3'h5: ccr_d = mem_rdata; // RULE10
                        3'h4: a_d = mem_rdata; // RULE9
                        3'h3: x_d = mem_rdata; // RULE9
                        3'h2: pc_d = {mem_rdata, pc_q[7:0]}; // RULE12
                        3'h1: pc_d = {pc_q[15:8], mem_rdata}; // RULE12
                        default: pc_d = pc_q;
                    endcase
                end
                else
                    st_d = RRS_WAIT;
            end
            RRS_WAIT:
            begin
                // pad each instruction out to its full cycle count
                cyc_d = cyc_q + CYC_ONE;
                if (cyc_q + CYC_ONE >= cyc_target(opc_q))
                begin
                    // RULE7 RULE11 RULE13 RULE16
                    if (opc_q == OP_STK_RELOAD)
                        sp_d = STACK_TOP; // RULE8
                    done_d = 1'b1;
                    st_d = RRS_FETCH;
                end
            end
            default:
                st_d = RRS_FETCH;
        endcase
    end

    // ****************
    // cycle targets
    // ****************
    function automatic logic [3:0] cyc_target(input logic [7:0] op);
        logic [3:0] c;
        c = CYC_IMM;
        unique case (op[7:4])
            4'h4, 4'h5: c = CYC_RMW_INH; // RULE7
            4'h3, 4'h7: c = CYC_RMW_IX;
            4'h6: c = CYC_RMW_IX1;
            4'hb: c = CYC_RD_DIR;
            4'hc: c = CYC_RD_EXT;
            4'hf: c = CYC_RD_IX;
            4'he: c = CYC_RD_IX1;
            4'hd: c = CYC_RD_IX2;
            default: c = CYC_IMM;
        endcase
        if (op == OP_INT_RETURN)
            c = CYC_RTI; // RULE11
        else if (op == OP_SUB_RETURN)
            c = CYC_RTS; // RULE13
        else if (op == OP_STK_RELOAD)
            c = CYC_STK; // RULE8
        return c;
    endfunction : cyc_target

    // ****************
    // registers
    // ****************
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= RRS_FETCH;
            kind_q <= RRS_K_NONE;
            a_q <= BYTE_ZERO;
            x_q <= BYTE_ZERO;
            ccr_q <= FLAGS_RESET;
            opc_q <= BYTE_ZERO;
            sp_q <= STACK_TOP;
            pc_q <= PC_RESET;
            ea_q <= PC_RESET;
            cyc_q <= CYC_ONE;
            pull_q <= 3'h0;
            ofs_q <= 2'h0;
            done_q <= 1'b0;
            ill_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            kind_q <= kind_d;
            a_q <= a_d;
            x_q <= x_d;
            ccr_q <= ccr_d;
            opc_q <= opc_d;
            sp_q <= sp_d;
            pc_q <= pc_d;
            ea_q <= ea_d;
            cyc_q <= cyc_d;
            pull_q <= pull_d;
            ofs_q <= ofs_d;
            done_q <= done_d;
            ill_q <= ill_d;
        end
    end

    // ****************
    // outputs
    // ****************
    assign accumulator = a_q;
    assign index_reg = x_q;
    assign stack_pointer = sp_q;
    assign program_counter = pc_q;
    assign condition_flags = ccr_q;
    assign instr_done = done_q;
    assign illegal_op = ill_q;
endmodule : rrs_exec

// *** core/rrs_pkg.sv ***
// constants for the rotate / return / subtract execution block
// assumes one 200 MHz core clock and byte-wide memory answering reads in the same cycle
// Operation
// RULE1: inclusive-or sets zero when the result is zero and copies bit 7 into negative.
// RULE2: rotate left moves the operand up one place and fills bit 0 from the old carry.
// RULE3: rotate left loads carry from the old bit 7, negative and zero follow the result.
// RULE4: rotate right moves the operand down one place and fills bit 7 from the old carry.
// RULE5: rotate right loads carry from the old bit 0.
// RULE6: both rotates set zero on an all-clear result, copy bit 7 to negative, keep half-carry and mask.
// RULE7: rotate accumulator opcodes are 49 and 46 at 3 cycles, memory forms 5, offset indexed 6.
// RULE8: stack top reload, opcode 9c, puts 00ff in the stack pointer in 2 cycles, flags kept.
// RULE9: interrupt return pulls flags, accumulator, index, pc high, pc low, pre-incrementing the pointer.
// RULE10: interrupt return loads every flag, mask included, from the pulled byte.
// RULE11: interrupt return is inherent opcode 80 and takes 9 cycles.
// RULE12: subroutine return pre-increments and pulls pc high, then pre-increments and pulls pc low.
// RULE13: subroutine return is opcode 81, 6 cycles, flags kept.
// RULE14: subtract with borrow puts a minus m minus carry in a, negative and zero from the result.
// RULE15: its carry is (!a7 & m7) | (m7 & r7) | (r7 & !a7).
// RULE16: subtract with borrow opcodes a2, b2, c2, f2, e2, d2, 2 to 5 cycles.
// RULE17: a flag not listed as affected keeps its previous value.
package rrs_pkg;
    // ****************
    // opcodes
    // ****************
    localparam logic [7:0] OP_OR_IMM = 8'haa;
    localparam logic [7:0] OP_OR_DIR = 8'hba;
    localparam logic [7:0] OP_OR_EXT = 8'hca;
    localparam logic [7:0] OP_OR_IX = 8'hfa;
    localparam logic [7:0] OP_OR_IX1 = 8'hea;
    localparam logic [7:0] OP_OR_IX2 = 8'hda;
    localparam logic [7:0] OP_ROL_A = 8'h49;
    localparam logic [7:0] OP_ROL_X = 8'h59;
    localparam logic [7:0] OP_ROL_DIR = 8'h39;
    localparam logic [7:0] OP_ROL_IX = 8'h79;
    localparam logic [7:0] OP_ROL_IX1 = 8'h69;
    localparam logic [7:0] OP_ROR_A = 8'h46;
    localparam logic [7:0] OP_ROR_X = 8'h56;
    localparam logic [7:0] OP_ROR_DIR = 8'h36;
    localparam logic [7:0] OP_ROR_IX = 8'h76;
    localparam logic [7:0] OP_ROR_IX1 = 8'h66;
    localparam logic [7:0] OP_STK_RELOAD = 8'h9c;
    localparam logic [7:0] OP_INT_RETURN = 8'h80;
    localparam logic [7:0] OP_SUB_RETURN = 8'h81;
    localparam logic [7:0] OP_SBC_IMM = 8'ha2;
    localparam logic [7:0] OP_SBC_DIR = 8'hb2;
    localparam logic [7:0] OP_SBC_EXT = 8'hc2;
    localparam logic [7:0] OP_SBC_IX = 8'hf2;
    localparam logic [7:0] OP_SBC_IX1 = 8'he2;
    localparam logic [7:0] OP_SBC_IX2 = 8'hd2;
    // ****************
    // flag positions in condition_flags
    // ****************
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_I = 3;
    localparam int FLG_H = 4;
    localparam int MSB = 7;
    // ****************
    // reset values and constants
    // ****************
    localparam logic [15:0] STACK_TOP = 16'h00ff;
    localparam logic [15:0] STACK_STEP = 16'h0001;
    localparam logic [15:0] PC_STEP = 16'h0001;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] FLAGS_RESET = 8'he8;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [3:0] CYC_ONE = 4'h1;
    localparam logic [3:0] CYC_IMM = 4'h2;
    localparam logic [3:0] CYC_RMW_INH = 4'h3;
    localparam logic [3:0] CYC_RMW_IX = 4'h5;
    localparam logic [3:0] CYC_RMW_IX1 = 4'h6;
    localparam logic [3:0] CYC_RTS = 4'h6;
    localparam logic [3:0] CYC_RTI = 4'h9;
    localparam logic [3:0] CYC_RD_DIR = 4'h3;
    localparam logic [3:0] CYC_RD_EXT = 4'h4;
    localparam logic [3:0] CYC_RD_IX = 4'h3;
    localparam logic [3:0] CYC_RD_IX1 = 4'h4;
    localparam logic [3:0] CYC_RD_IX2 = 4'h5;
    localparam logic [3:0] CYC_STK = 4'h2;
    localparam logic [2:0] PULLS_RTI = 3'h5;
    localparam logic [2:0] PULLS_RTS = 3'h2;

    typedef enum logic [3:0] {
        RRS_FETCH = 4'b0001,
        RRS_OPER = 4'b0010,
        RRS_PULL = 4'b0100,
        RRS_WAIT = 4'b1000
    } rrs_state_t;

    typedef enum logic [2:0] {
        RRS_K_OR = 3'h0,
        RRS_K_ROL = 3'h1,
        RRS_K_ROR = 3'h2,
        RRS_K_SBC = 3'h3,
        RRS_K_NONE = 3'h4
    } rrs_kind_t;
endpackage : rrs_pkg

// *** testbench/rrs_mem.sv ***
// byte-wide memory model answering reads in the same cycle
// assumes the bench preloads program and stack bytes through mem
module rrs_mem
(
    input wire logic core_clk,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;
    // unread cycles show the inverse of the last byte, never a stale match
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
    always @(posedge core_clk)
    begin
        if (mem_rd)
            last_q <= mem[mem_addr];
        if (mem_wr)
            mem[mem_addr] <= mem_wdata;
    end
endmodule : rrs_mem

// *** testbench/rrs_exec_assertions.sv ***
// port checker for the execution core
// assumes the immediate operand is read the cycle after the opcode
module rrs_exec_assertions
    import rrs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] accumulator,
    input wire logic [7:0] index_reg,
    input wire logic [15:0] stack_pointer,
    input wire logic [15:0] program_counter,
    input wire logic [7:0] condition_flags,
    input wire logic instr_done,
    input wire logic illegal_op
);
    // ****************
    // fetch tracking
    // ****************
    logic fq_q, fq_d, pf_q, pf_d, fetch;
    logic [7:0] op_q, op_d, a_q, a_d, f_q, f_d, m_q, m_d;
    logic [15:0] sp_q, sp_d;
    // done pulses in the next fetch cycle, so it marks that fetch
    assign fetch = (fq_q | instr_done) & mem_rd;
    always_comb
    begin
        fq_d = fq_q & ~mem_rd;
        pf_d = fetch;
        op_d = fetch ? mem_rdata : op_q;
        a_d = fetch ? accumulator : a_q;
        f_d = fetch ? condition_flags : f_q;
        sp_d = fetch ? stack_pointer : sp_q;
        m_d = (pf_q & mem_rd) ? mem_rdata : m_q;
    end
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            fq_q <= 1'b1;
            pf_q <= 1'b0;
            op_q <= 8'h00;
            a_q <= 8'h00;
            f_q <= 8'h00;
            sp_q <= 16'h0000;
            m_q <= 8'h00;
        end
        else
        begin
            fq_q <= fq_d;
            pf_q <= pf_d;
            op_q <= op_d;
            a_q <= a_d;
            f_q <= f_d;
            sp_q <= sp_d;
            m_q <= m_d;
        end
    end
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_rol_acc: assert property (fetch && mem_rdata == OP_ROL_A |-> ##3
        instr_done && accumulator == {a_q[6:0], f_q[FLG_C]}
        && condition_flags[FLG_C] == a_q[7]) else $error("rotate left wrong");
    a_ror_acc: assert property (fetch && mem_rdata == OP_ROR_A |-> ##3
        instr_done && accumulator == {f_q[FLG_C], a_q[7:1]}
        && condition_flags[FLG_C] == a_q[0]) else $error("rotate right wrong");
    a_rot_flags: assert property (instr_done && (op_q == OP_ROL_A ||
        op_q == OP_ROR_A) |-> condition_flags[FLG_N] == accumulator[7]
        && condition_flags[FLG_Z] == (accumulator == BYTE_ZERO)
        && condition_flags[FLG_H] == f_q[FLG_H]
        && condition_flags[FLG_I] == f_q[FLG_I]) else $error("rotate flags");
    a_stk_reload: assert property (fetch && mem_rdata == OP_STK_RELOAD |-> ##2
        instr_done && stack_pointer == STACK_TOP && condition_flags == f_q)
        else $error("stack reload wrong");
    a_rti_length: assert property (fetch && mem_rdata == OP_INT_RETURN |=>
        !instr_done [*8] ##1 instr_done) else $error("interrupt return length");
    a_rts_keep: assert property (fetch && mem_rdata == OP_SUB_RETURN |-> ##6
        instr_done && condition_flags == f_q
        && stack_pointer == sp_q + STACK_STEP + STACK_STEP)
        else $error("subroutine return wrong");
    a_sbc_math: assert property (instr_done && op_q == OP_SBC_IMM |->
        accumulator == a_q - m_q - {7'h00, f_q[FLG_C]}
        && condition_flags[FLG_C] == ((~a_q[7] & m_q[7]) | (m_q[7] &
        accumulator[7]) | (accumulator[7] & ~a_q[7]))
        && condition_flags[FLG_N] == accumulator[7]) else $error("subtract");
    a_sbc_len: assert property (fetch && mem_rdata == OP_SBC_IMM |-> ##2
        instr_done) else $error("subtract immediate length");
    a_or_flags: assert property (instr_done && op_q == OP_OR_IMM |->
        accumulator == (a_q | m_q) && condition_flags[FLG_N] == accumulator[7]
        && condition_flags[FLG_Z] == (accumulator == BYTE_ZERO)
        && condition_flags[FLG_C] == f_q[FLG_C]) else $error("or flags");
    c_rti: cover property (fetch && mem_rdata == OP_INT_RETURN);
    c_rts: cover property (fetch && mem_rdata == OP_SUB_RETURN);
    c_sbc: cover property (fetch && mem_rdata == OP_SBC_IMM);
    c_rmw: cover property (mem_wr && mem_rd);
    a_ill_keep: assert property (illegal_op |-> accumulator == a_q
        && condition_flags == f_q ##1 instr_done)
        else $error("unknown opcode changed state");
endmodule : rrs_exec_assertions

bind rrs_exec rrs_exec_assertions i_rrs_exec_assertions (.core_clk, .rst,
    .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .accumulator,
    .index_reg, .stack_pointer, .program_counter, .condition_flags,
    .instr_done, .illegal_op);

// *** testbench/tb_rrs_exec.sv ***
// program-driven bench for the execution core
// assumes the memory model and the bound checker
module tb_rrs_exec
    import rrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] mem_addr, stack_pointer, program_counter;
    logic mem_rd, mem_wr, instr_done, illegal_op;
    logic [7:0] mem_wdata, mem_rdata, accumulator, index_reg, condition_flags;
    int errors = 0;
    int check_count = 0;
    int n;
    int ill_count = 0;
    // a, x, flags, sp, pc, cycles since previous retire (0 = skip)
    logic [63:0] exp_t [17] = '{64'hff_00_ed_00ff_0002_00,
        64'hff_00_ed_00ff_0003_03, 64'hff_00_ed_00ff_0004_03,
        64'h00_00_ea_00ff_0006_02, 64'h00_00_ea_00ff_0007_03,
        64'h80_00_ec_00ff_0009_02, 64'h00_00_eb_00ff_000a_03,
        64'h80_00_ec_00ff_000b_03, 64'h3c_5a_f3_0104_0020_09,
        64'h3c_b5_f4_0104_0021_03, 64'h3c_b5_f4_00ff_0022_02,
        64'h3c_b5_f4_0101_f33c_06, 64'h00_b5_f2_0101_f33e_02,
        64'h00_b5_f1_0101_f340_05, 64'h00_b5_f5_0101_f342_06,
        64'h00_b5_f5_0101_f343_02, 64'h02_b5_f1_0101_f345_03};
    logic [7:0] prog [12] = '{8'ha2, 8'h01, 8'h49, 8'h46, 8'ha2, 8'hfe,
        8'h49, 8'haa, 8'h80, 8'h49, 8'h46, 8'h80};
    // memory rotates, an unknown code, a direct or; the trailing 9c is fetched as the run ends, never checked
    logic [7:0] prog2 [8] = '{8'h39, 8'h40, 8'h66, 8'h10, 8'h01, 8'hba,
        8'h40, 8'h9c};
    always @(posedge core_clk)
        if (illegal_op === 1'b1)
            ill_count++;
    always #2.5 core_clk = ~core_clk;
    rrs_exec i_rrs_exec (.core_clk, .rst, .mem_addr, .mem_rd, .mem_wr,
        .mem_wdata, .mem_rdata, .accumulator, .index_reg, .stack_pointer,
        .program_counter, .condition_flags, .instr_done, .illegal_op);
    rrs_mem i_rrs_mem (.core_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
        .mem_rdata);
    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // bounded so a core that never retires still ends the step
    task automatic wait_done(output int cnt);
        cnt = 0;
        do
        begin
            @(posedge core_clk);
            #1;
            cnt++;
        end
        while (instr_done !== 1'b1 && cnt < 20);
    endtask : wait_done
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    initial
    begin
        for (int i = 0; i < 12; i++)
            i_rrs_mem.mem[i] = prog[i];
        {i_rrs_mem.mem[16'h0020], i_rrs_mem.mem[16'h0021]} = 16'h599c;
        i_rrs_mem.mem[16'h0022] = OP_SUB_RETURN;
        {i_rrs_mem.mem[16'h0100], i_rrs_mem.mem[16'h0101]} = 16'hf33c;
        {i_rrs_mem.mem[16'h0102], i_rrs_mem.mem[16'h0103]} = 16'h5a00;
        i_rrs_mem.mem[16'h0104] = 8'h20;
        {i_rrs_mem.mem[16'hf33c], i_rrs_mem.mem[16'hf33d]} = 16'ha23c;
        for (int i = 0; i < 8; i++)
            i_rrs_mem.mem[16'hf33e + 16'(i)] = prog2[i];
        i_rrs_mem.mem[16'h0040] = 8'h81;
        i_rrs_mem.mem[16'h00c5] = 8'h01;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        for (int s = 0; s < 17; s++)
        begin
            wait_done(n);
            check("accumulator", {8'h00, exp_t[s][63:56]}, {8'h00, accumulator});
            check("index", {8'h00, exp_t[s][55:48]}, {8'h00, index_reg});
            check("flags", {8'h00, exp_t[s][47:40]}, {8'h00, condition_flags});
            check("stack", exp_t[s][39:24], stack_pointer);
            check("pc", exp_t[s][23:8], program_counter);
            if (exp_t[s][7:0] != 8'h00)
                check("cycles", exp_t[s][15:0] & 16'h00ff, 16'(n));
        end
        check("byte 0040", 16'h0002, {8'h00, i_rrs_mem.mem[16'h0040]});
        check("byte 00c5", 16'h0080, {8'h00, i_rrs_mem.mem[16'h00c5]});
        check("unknown codes", 16'h0001, 16'(ill_count));
        $display("program sequence test done");
        stop_test();
    end
    initial
    begin
        #(400 * 5);
        errors++;
        stop_test();
    end
endmodule : tb_rrs_exec
